// *** ram_lane_block.sv ***
// dual-port ram with lane write mask and per-port address hold
//
// Function
// - in 20-bit width mask bit 1 gates bits 19:10 and bit 0 gates bits 9:0, all ones by default.
// - in 40-bit width each of four mask bits gates one 10-bit lane, msb to the top lane.
// - a write happens only with write strobe high and only into lanes whose mask bit is high.
// - in the large ram type the read output of a masked lane during a write is don't care.
// - in the lut ram type a masked lane reads don't care or current contents, per a setting.
// - packed mode runs the large ram as two single-port memories, port a in the lower half and port b in the upper half.
// - while address hold is high and reset is low the registered address keeps its value.
// - each port has its own address hold acting only on its own address register.
// - address hold defaults low so the address loads on every edge.
// - lanes not enabled during a write keep their stored contents.
// - mask bits are active high, msb and lsb matching msb and lsb lanes.
`timescale 1ns/1ps
`include "ram_lane_cfg.svh"
module ram_lane_block (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// static configuration
	input wire ram_lane_pkg::ram_cfg_t CFG,
	// port requests
	input wire ram_lane_pkg::port_req_t REQ_A,
	input wire ram_lane_pkg::port_req_t REQ_B,
	// read data
	output logic [`RAM_DATA_W-1:0] RDATA_A,
	output logic [`RAM_DATA_W-1:0] RDATA_B
);
	ram_lane_pkg::port_req_t req [2];
	ram_lane_pkg::addr_t addr_q [2];
	ram_lane_pkg::addr_t addr_d [2];
	ram_lane_pkg::mask_t mask_q [2];
	ram_lane_pkg::mask_t mask_d [2];
	ram_lane_pkg::mask_t emask [2];
	ram_lane_pkg::data_t data_q [2];
	ram_lane_pkg::data_t data_d [2];
	ram_lane_pkg::data_t rdata_q [2];
	ram_lane_pkg::data_t rdata_d [2];
	ram_lane_pkg::addr_t ea [2];
	logic wr_q [2];
	logic wr_d [2];
	logic [`RAM_DATA_W-1:0] mem [`RAM_DEPTH];

	assign req[0] = REQ_A;
	assign req[1] = REQ_B;
	assign RDATA_A = rdata_q[0];
	assign RDATA_B = rdata_q[1];

	// input register next values
	always_comb
	begin
		for (int p = 0; p < 2; p++)
		begin
			addr_d[p] = req[p].addr_hold ? addr_q[p] : req[p].addr;
			wr_d[p] = req[p].wren;
			mask_d[p] = req[p].mask;
			data_d[p] = req[p].data;
		end
	end

	// input registers
	always_ff @(posedge CLK)
	begin
		for (int p = 0; p < 2; p++)
		begin
			if (RST)
			begin
				addr_q[p] <= `RAM_ADDR_RESET;
				wr_q[p] <= 1'b0;
				mask_q[p] <= `RAM_MASK_RESET;
				data_q[p] <= '0;
			end
			else
			begin
				addr_q[p] <= addr_d[p];
				wr_q[p] <= wr_d[p];
				mask_q[p] <= mask_d[p];
				data_q[p] <= data_d[p];
			end
		end
	end

	// effective mask and address per port
	always_comb
	begin
		for (int p = 0; p < 2; p++)
		begin
			// narrow width uses two low mask bits
			// wide width uses all four lanes
			// active high, msb to top lane
			if (CFG.wide_mode)
				emask[p] = mask_q[p];
			else
				emask[p] = {2'b00, mask_q[p][`RAM_NARROW_LANES-1:0]};
			// port number replaces the address msb to pick the logical memory
			if (CFG.packed_mode)
				ea[p] = {p[0], addr_q[p][`RAM_ADDR_W-2:0]};
			else
				ea[p] = addr_q[p];
		end
	end

	// read data next values
	always_comb
	begin
		logic [`RAM_DATA_W-1:0] old;
		old = '0;
		for (int p = 0; p < 2; p++)
		begin
			old = mem[ea[p]];
			for (int l = 0; l < `RAM_LANES; l++)
			begin
				if (!CFG.wide_mode && l >= `RAM_NARROW_LANES)
					rdata_d[p][l*`RAM_LANE_W +: `RAM_LANE_W] = '0;
				else if (wr_q[p] && emask[p][l])
					rdata_d[p][l*`RAM_LANE_W +: `RAM_LANE_W] = data_q[p][l*`RAM_LANE_W +: `RAM_LANE_W];
				// lut type may show current contents
				else if (wr_q[p] && CFG.lut_type && CFG.lut_keep_current)
					rdata_d[p][l*`RAM_LANE_W +: `RAM_LANE_W] = old[l*`RAM_LANE_W +: `RAM_LANE_W];
				// masked lane reads as don't care, shown as zero
				else if (wr_q[p])
					rdata_d[p][l*`RAM_LANE_W +: `RAM_LANE_W] = '0;
				else
					rdata_d[p][l*`RAM_LANE_W +: `RAM_LANE_W] = old[l*`RAM_LANE_W +: `RAM_LANE_W];
			end
		end
	end

	// read data registers
	always_ff @(posedge CLK)
	begin
		for (int p = 0; p < 2; p++)
		begin
			if (RST)
				rdata_q[p] <= '0;
			else
				rdata_q[p] <= rdata_d[p];
		end
	end

	// memory array, port b written last on a shared address
	always_ff @(posedge CLK)
	begin
		for (int p = 0; p < 2; p++)
		begin
			for (int l = 0; l < `RAM_LANES; l++)
			begin
				// strobe and lane bit both needed
				if (!RST && wr_q[p] && emask[p][l])
					mem[ea[p]][l*`RAM_LANE_W +: `RAM_LANE_W] <= data_q[p][l*`RAM_LANE_W +: `RAM_LANE_W];
			end
		end
	end

	// helpers for the checks
	logic [`RAM_LANE_W-1:0] old_lane0_a;
	logic b_hits_a;
	assign old_lane0_a = mem[ea[0]][`RAM_LANE_W-1:0];
	assign b_hits_a = wr_q[1] && (ea[1] == ea[0]) && emask[1][0];

	AST_HOLD_KEEPS_ADDR:
	assert property (@(posedge CLK) disable iff (RST)
		REQ_A.addr_hold ##1 REQ_A.addr_hold |=> addr_q[0] == $past(addr_q[0], 2))
	else $error("held address changed");

	AST_ADDR_LOADS:
	assert property (@(posedge CLK) disable iff (RST)
		!REQ_A.addr_hold |=> addr_q[0] == $past(REQ_A.addr))
	else $error("address not loaded without hold");

	AST_HOLD_PER_PORT:
	assert property (@(posedge CLK) disable iff (RST)
		REQ_B.addr_hold && !REQ_A.addr_hold |=> addr_q[1] == $past(addr_q[1]) && addr_q[0] == $past(REQ_A.addr))
	else $error("hold leaked between ports");

	AST_HOLD_ON_WRITE:
	assert property (@(posedge CLK) disable iff (RST)
		REQ_B.addr_hold && REQ_B.wren |=> addr_q[1] == $past(addr_q[1]) && wr_q[1])
	else $error("hold ignored on write");

	AST_LARGE_MASKED_ZERO:
	assert property (@(posedge CLK) disable iff (RST)
		wr_q[0] && !CFG.lut_type && !mask_q[0][0] |=> RDATA_A[`RAM_LANE_W-1:0] == '0)
	else $error("masked lane output not don't care value");

	AST_LUT_KEEPS_CURRENT:
	assert property (@(posedge CLK) disable iff (RST)
		wr_q[0] && CFG.lut_type && CFG.lut_keep_current && !mask_q[0][0]
		|=> RDATA_A[`RAM_LANE_W-1:0] == $past(old_lane0_a))
	else $error("lut masked lane lost current data");

	AST_TOP_LANE_WRITTEN:
	assert property (@(posedge CLK) disable iff (RST)
		wr_q[0] && CFG.wide_mode && mask_q[0][3] |=> RDATA_A[39:30] == $past(data_q[0][39:30]))
	else $error("top lane not written through");

	AST_MASKED_LANE_KEPT:
	assert property (@(posedge CLK) disable iff (RST)
		wr_q[0] && !emask[0][0] && !b_hits_a
		|=> mem[$past(ea[0])][`RAM_LANE_W-1:0] == $past(old_lane0_a))
	else $error("masked lane contents changed");

	AST_NARROW_UPPER_ZERO:
	assert property (@(posedge CLK) disable iff (RST)
		!CFG.wide_mode |=> RDATA_A[39:20] == '0 && RDATA_B[39:20] == '0)
	else $error("narrow width upper bits active");

	AST_PACKED_MSB:
	assert property (@(posedge CLK) disable iff (RST)
		CFG.packed_mode && wr_q[1] && emask[1][0]
		|=> mem[{1'b1, $past(addr_q[1][`RAM_ADDR_W-2:0])}][`RAM_LANE_W-1:0]
			== $past(data_q[1][`RAM_LANE_W-1:0]))
	else $error("packed mode memory select wrong");

	// main scenarios
	COV_HELD_WRITE: cover property (@(posedge CLK) disable iff (RST)
		REQ_A.addr_hold && REQ_A.wren ##1 REQ_A.addr_hold && REQ_A.wren);
	COV_PARTIAL_WRITE: cover property (@(posedge CLK) disable iff (RST)
		wr_q[0] && CFG.wide_mode && mask_q[0] == 4'h8);
	COV_PACKED_BOTH: cover property (@(posedge CLK) disable iff (RST)
		CFG.packed_mode && wr_q[0] && wr_q[1]);
	COV_LUT_KEEP: cover property (@(posedge CLK) disable iff (RST)
		wr_q[1] && CFG.lut_type && CFG.lut_keep_current && mask_q[1] != 4'hf);
endmodule : ram_lane_block

// *** ram_lane_block_tb.sv ***
// self-checking bench of the lane-masked ram
`timescale 1ns/1ps
module ram_lane_block_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ram_lane_pkg::ram_cfg_t cfg = 4'h8;
	ram_lane_pkg::port_req_t want_a = '0;
	ram_lane_pkg::port_req_t want_b = '0;
	ram_lane_pkg::port_req_t req_a;
	ram_lane_pkg::port_req_t req_b;
	ram_lane_pkg::data_t rd_a;
	ram_lane_pkg::data_t rd_b;
	ram_lane_pkg::data_t da = 40'h12345_6789a;
	ram_lane_pkg::data_t db = 40'hfedcb_a9876;
	ram_lane_pkg::data_t old;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	// user logic in front of each port
	ram_user_model mod_a (.CLK(clk), .PACKED(cfg.packed_mode), .WANT(want_a), .REQ(req_a));
	ram_user_model mod_b (.CLK(clk), .PACKED(cfg.packed_mode), .WANT(want_b), .REQ(req_b));
	ram_lane_block dut_u (.CLK(clk), .RST(rst), .CFG(cfg), .REQ_A(req_a), .REQ_B(req_b),
		.RDATA_A(rd_a), .RDATA_B(rd_b));
	// clock and hang guard
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			fail_count++;
			complete_run;
		end
	end
	// lanes of n where mask set, else of o
	function automatic ram_lane_pkg::data_t mix(ram_lane_pkg::mask_t m,
		ram_lane_pkg::data_t n, ram_lane_pkg::data_t o);
		for (int l = 0; l < 4; l++)
			mix[l*10 +: 10] = m[l] ? n[l*10 +: 10] : o[l*10 +: 10];
	endfunction : mix
	task chk(input string nm, input ram_lane_pkg::data_t e, input ram_lane_pkg::data_t g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one request, write dropped after one cycle, returns when read data is due
	task op(input logic pb, input logic w, input ram_lane_pkg::mask_t m,
		input ram_lane_pkg::addr_t ad, input logic h, input ram_lane_pkg::data_t d);
		ram_lane_pkg::port_req_t r;
		r = {w, m, ad, h, d};
		@(posedge clk);
		if (pb)
			want_b <= r;
		else
			want_a <= r;
		@(posedge clk);
		want_a.wren <= 1'b0;
		want_b.wren <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : op
	task wide_lanes;
		op(0, 1, 4'hf, 8'h05, 0, da);
		chk("wide full", da, rd_a);
		old = da;
		for (int l = 0; l < 4; l++)
		begin
			op(0, 1, 4'h1 << l, 8'h05, 0, db);
			chk("masked out", mix(4'h1 << l, db, '0), rd_a);
			op(0, 0, 4'hf, 8'h05, 0, da);
			old = mix(4'h1 << l, db, old);
			chk("kept lanes", old, rd_a);
		end
	endtask : wide_lanes
	task narrow;
		@(posedge clk) cfg <= 4'h0;
		op(0, 1, 4'hf, 8'h06, 0, da);
		chk("narrow full", mix(4'h3, da, '0), rd_a);
		op(0, 1, 4'hd, 8'h06, 0, db);
		op(0, 0, 4'h0, 8'h06, 0, '0);
		chk("narrow lane", mix(4'h1, db, mix(4'h3, da, '0)), rd_a);
	endtask : narrow
	task lut;
		@(posedge clk) cfg <= 4'he;
		op(0, 1, 4'hf, 8'h07, 0, da);
		op(0, 1, 4'h6, 8'h07, 0, db);
		chk("lut keep", mix(4'h6, db, da), rd_a);
		op(1, 1, 4'h1, 8'h07, 0, ~da);
		chk("lut keep b", mix(4'h1, ~da, mix(4'h6, db, da)), rd_b);
		@(posedge clk) cfg <= 4'hc;
		op(0, 1, 4'h9, 8'h07, 0, db);
		chk("lut zero", mix(4'h9, db, '0), rd_a);
	endtask : lut
	task hold;
		@(posedge clk) cfg <= 4'h8;
		op(0, 1, 4'hf, 8'h15, 0, db);
		op(0, 1, 4'hf, 8'h14, 0, da);
		op(1, 0, 4'hf, 8'h15, 0, '0);
		op(0, 0, 4'hf, 8'h15, 1, '0);
		chk("held read", da, rd_a);
		chk("other port", db, rd_b);
		op(0, 1, 4'hf, 8'h15, 1, ~da);
		op(0, 0, 4'hf, 8'h15, 0, '0);
		chk("released", db, rd_a);
		op(0, 0, 4'hf, 8'h14, 0, '0);
		chk("held write", ~da, rd_a);
	endtask : hold
	task hold_b;
		op(1, 1, 4'hf, 8'h21, 0, ~db);
		op(1, 1, 4'hf, 8'h20, 0, da);
		op(1, 1, 4'hf, 8'h21, 1, db);
		op(1, 0, 4'hf, 8'h21, 0, '0);
		chk("b held write kept", ~db, rd_b);
		op(1, 0, 4'hf, 8'h20, 0, '0);
		chk("b held write", db, rd_b);
		chk("a during b hold", ~da, rd_a);
	endtask : hold_b
	task packed_mode;
		@(posedge clk) cfg <= 4'h9;
		op(0, 1, 4'hf, 8'h03, 0, da);
		op(1, 1, 4'hf, 8'h03, 0, db);
		@(posedge clk) cfg <= 4'h8;
		op(0, 0, 4'hf, 8'h83, 0, '0);
		op(1, 0, 4'hf, 8'h03, 0, '0);
		chk("upper half", db, rd_a);
		chk("lower half", da, rd_b);
	endtask : packed_mode
	task reset_mid;
		op(0, 1, 4'hf, 8'h00, 0, db);
		op(0, 1, 4'hf, 8'h01, 0, da);
		@(posedge clk);
		rst <= 1'b1;
		want_a.addr_hold <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("reset read a", '0, rd_a);
		chk("reset read b", '0, rd_b);
		@(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("held reset address", db, rd_a);
	endtask : reset_mid
	task complete_run;
		if (fail_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wide_lanes;
		narrow;
		lut;
		hold;
		hold_b;
		packed_mode;
		reset_mid;
		complete_run;
	end
endmodule : ram_lane_block_tb

// *** ram_lane_cfg.svh ***
// sizes, reset values and defaults of the lane-masked ram
`ifndef RAM_LANE_CFG_SVH
`define RAM_LANE_CFG_SVH
`define RAM_DATA_W 40
`define RAM_LANE_W 10
`define RAM_LANES 4
`define RAM_ADDR_W 8
`define RAM_DEPTH 256
`define RAM_MASK_RESET 4'hf
`define RAM_ADDR_RESET 8'h00
`define RAM_NARROW_LANES 2
`endif

// *** ram_lane_pkg.sv ***
// types shared by the lane-masked ram
package ram_lane_pkg;
	typedef logic [39:0] data_t;
	typedef logic [7:0] addr_t;
	typedef logic [3:0] mask_t;
	// one port request as presented by user logic
	typedef struct packed {
		logic wren;
		mask_t mask;
		addr_t addr;
		logic addr_hold;
		data_t data;
	} port_req_t;
	// static configuration of the block
	typedef struct packed {
		logic wide_mode;
		logic lut_type;
		logic lut_keep_current;
		logic packed_mode;
	} ram_cfg_t;
endpackage : ram_lane_pkg

// *** ram_user_model.sv ***
// user logic model driving one ram port
`timescale 1ns/1ps
module ram_user_model (
	// clock and mode
	input wire logic CLK,
	input wire logic PACKED,
	// wanted and driven request
	input wire ram_lane_pkg::port_req_t WANT,
	output ram_lane_pkg::port_req_t REQ
);
	ram_lane_pkg::port_req_t next_req;

	// request kept in the lower half when packed
	always_comb
	begin
		next_req = WANT;
		next_req.addr[7] = WANT.addr[7] & ~PACKED;
	end

	// registers the request
	always_ff @(posedge CLK)
	begin
		REQ <= next_req;
	end
endmodule : ram_user_model
